// ===== verilog/tma_pkg.sv
// Constants, register map and enumerations of the three-channel timer.
// Assumes a 32-bit AXI4-Lite slave with byte addresses of aligned words.
// Operation
// - Channels idle until their start bit is set
// - Counter reads return the live count
// - Timer mode read during reload gives all ones
// - Stopped write then read returns written value
// - Event reads: underflow all ones, overflow zeros
// - One-shot stop: halt, reload, output low
// - One-shot stop raises request one cycle later
// - One-shot output aligned to count source
// - Selecting one-shot mode raises a request
// - Retrigger: count once more, reload, continue
package tma_pkg;
   // Byte offsets
   localparam logic [7:0] OFF_START = 8'h00;
   localparam logic [7:0] OFF_ONESHOT = 8'h04;
   localparam logic [7:0] OFF_TRIGSEL = 8'h08;
   localparam logic [7:0] OFF_UPDOWN = 8'h0C;
   localparam logic [7:0] OFF_IRQ_ST = 8'h10;
   localparam logic [7:0] OFF_IRQ_MSK = 8'h14;
   localparam logic [7:0] OFF_MODE0 = 8'h20;
   localparam logic [7:0] OFF_COUNT0 = 8'h30;
   localparam logic [7:0] CH_STRIDE = 8'h04;
   // Mode register fields
   localparam int MODE_LSB = 0;
   localparam int SRC_BIT = 2;
   // Trigger select field width per channel
   localparam int TSEL_W = 2;
   // Reset and special values
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [15:0] ALL_ONES = 16'hFFFF;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam int PRESCALE_DEF = 8;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   typedef enum logic [1:0] {
      TMA_MODE_TIMER = 2'b00,
      TMA_MODE_EVENT = 2'b01,
      TMA_MODE_ONESHOT = 2'b10,
      TMA_MODE_RSVD = 2'b11
   } tma_mode_t;
   typedef enum logic [1:0] {
      TMA_TRG_SW = 2'b00,
      TMA_TRG_FALL = 2'b01,
      TMA_TRG_RISE = 2'b10,
      TMA_TRG_BOTH = 2'b11
   } tma_trig_t;
   typedef enum logic {
      TMA_BUS_IDLE = 1'b0,
      TMA_BUS_RESP = 1'b1
   } tma_bus_t;
endpackage

// ===== verilog/tma_regbus_if.sv
// Internal register strobe bus between the AXI slave and the timer core.
// Assumes one clock; strobes are single-cycle, read data is combinational.
`timescale 1ns/100ps
interface tma_regbus_if;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic rd_en;
   logic [7:0] rd_addr;
   logic [31:0] rd_data;
   modport bus (output wr_en, output wr_addr, output wr_data,
      output rd_en, output rd_addr, input rd_data);
   modport regs (input wr_en, input wr_addr, input wr_data,
      input rd_en, input rd_addr, output rd_data);
endinterface

// ===== verilog/tma_axil_slave.sv
// AXI4-Lite slave that turns bus transfers into register strobes.
// Assumes the core answers reads in the same cycle as the strobe.
`timescale 1ns/100ps
module tma_axil_slave (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   tma_regbus_if.bus rb
);
   typedef struct packed {
      tma_pkg::tma_bus_t wst;
      tma_pkg::tma_bus_t rst;
      logic [31:0] rdata;
   } tma_axs_t;
   tma_axs_t s_reg;
   tma_axs_t s_next;
   logic wr_go;
   logic rd_go;

   ////////////////////////////////////////////////////////////////////////
   // Address and data are taken together so no skid storage is needed
   assign wr_go = awvalid && wvalid && (s_reg.wst == tma_pkg::TMA_BUS_IDLE);
   assign rd_go = arvalid && (s_reg.rst == tma_pkg::TMA_BUS_IDLE);
   assign awready = wr_go;
   assign wready = wr_go;
   assign arready = rd_go;
   assign bvalid = (s_reg.wst == tma_pkg::TMA_BUS_RESP);
   assign rvalid = (s_reg.rst == tma_pkg::TMA_BUS_RESP);
   assign bresp = tma_pkg::RESP_OKAY;
   assign rresp = tma_pkg::RESP_OKAY;
   assign rdata = s_reg.rdata;
   // Partial writes are dropped; registers are only written whole
   assign rb.wr_en = wr_go && (wstrb == 4'hF);
   assign rb.wr_addr = awaddr;
   assign rb.wr_data = wdata;
   assign rb.rd_en = rd_go;
   assign rb.rd_addr = araddr;

   // Response state of both channels
   always_comb begin
      s_next = s_reg;
      case (s_reg.wst)
         tma_pkg::TMA_BUS_IDLE: if (wr_go) s_next.wst = tma_pkg::TMA_BUS_RESP;
         tma_pkg::TMA_BUS_RESP: if (bready) s_next.wst = tma_pkg::TMA_BUS_IDLE;
         default: s_next.wst = tma_pkg::TMA_BUS_IDLE;
      endcase
      case (s_reg.rst)
         tma_pkg::TMA_BUS_IDLE: begin
            if (rd_go) begin
               s_next.rst = tma_pkg::TMA_BUS_RESP;
               s_next.rdata = rb.rd_data;
            end
         end
         tma_pkg::TMA_BUS_RESP: if (rready) s_next.rst = tma_pkg::TMA_BUS_IDLE;
         default: s_next.rst = tma_pkg::TMA_BUS_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule

// ===== verilog/tma_timer.sv
// Three-channel 16-bit timer core: timer, event counter and one-shot modes.
// Assumes AXI4-Lite from the bus slave; input pins are asynchronous.
`timescale 1ns/100ps
module tma_timer #(
   parameter int NCH = 3,
   parameter int PRESCALE = tma_pkg::PRESCALE_DEF
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [NCH-1:0] timer_input_pin,
   output logic [NCH-1:0] timer_output_pin,
   output logic irq
);
   // Address map holds at most four channels
   if (NCH < 1 || NCH > 4) begin : g_nch_chk
      $error("NCH must be 1 to 4");
   end
   if (PRESCALE < 2 || PRESCALE > 65536) begin : g_pre_chk
      $error("PRESCALE must be 2 to 65536");
   end

   localparam logic [15:0] PRE_LAST = 16'(PRESCALE - 1);

   typedef struct packed {
      logic [NCH-1:0] start;
      logic [NCH-1:0][7:0] mode;
      logic [NCH-1:0][15:0] cnt;
      logic [NCH-1:0][15:0] rld;
      logic [NCH-1:0] updn;
      logic [7:0] oneshot_start_flags_reg;
      logic [7:0] tsel;
      logic [NCH-1:0] irq_st;
      logic [NCH-1:0] irq_msk;
      logic [NCH-1:0] run;
      logic [NCH-1:0] out;
      logic [NCH-1:0] pend1;
      logic [NCH-1:0] pend2;
      logic [NCH-1:0] stop_d;
      logic [NCH-1:0] sync1;
      logic [NCH-1:0] sync2;
      logic [NCH-1:0] prev;
      logic [15:0] div;
   } tma_st_t;

   tma_st_t st_reg;
   tma_st_t st_next;
   tma_regbus_if rb ();

   logic div_tick;
   logic [NCH-1:0] tick;
   logic [NCH-1:0] rise;
   logic [NCH-1:0] fall;
   logic [NCH-1:0] reload_now;
   logic [NCH-1:0] over_now;

   ////////////////////////////////////////////////////////////////////////
   // Bus slave
   tma_axil_slave u_slave (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .rb(rb)
   );

   ////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic tma_pkg::tma_mode_t mode_of(input logic [7:0] m);
      return tma_pkg::tma_mode_t'(m[tma_pkg::MODE_LSB +: 2]);
   endfunction

   function automatic logic [7:0] ch_addr(input logic [7:0] base, input int i);
      return base + 8'(i * 4);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Count-source strobes and pin edges
   assign div_tick = (st_reg.div == PRE_LAST);
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         tick[i] = st_reg.mode[i][tma_pkg::SRC_BIT] ? div_tick : 1'b1;
         rise[i] = st_reg.sync2[i] && !st_reg.prev[i];
         fall[i] = !st_reg.sync2[i] && st_reg.prev[i];
      end
   end

   // Reload and overflow moments, seen by reads in the same cycle
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         reload_now[i] = 1'b0;
         over_now[i] = 1'b0;
         if (st_reg.start[i]) begin
            case (mode_of(st_reg.mode[i]))
               tma_pkg::TMA_MODE_TIMER:
                  reload_now[i] = tick[i] && (st_reg.cnt[i] == tma_pkg::CNT_RST);
               tma_pkg::TMA_MODE_EVENT: begin
                  reload_now[i] = rise[i] && !st_reg.updn[i]
                     && (st_reg.cnt[i] == tma_pkg::CNT_RST);
                  over_now[i] = rise[i] && st_reg.updn[i]
                     && (st_reg.cnt[i] == tma_pkg::ALL_ONES);
               end
               default: reload_now[i] = 1'b0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register read mux
   always_comb begin
      rb.rd_data = '0;
      case (rb.rd_addr)
         tma_pkg::OFF_START: rb.rd_data = 32'(st_reg.start);
         tma_pkg::OFF_ONESHOT: rb.rd_data = {24'h000000, st_reg.oneshot_start_flags_reg};
         tma_pkg::OFF_TRIGSEL: rb.rd_data = {24'h000000, st_reg.tsel};
         tma_pkg::OFF_UPDOWN: rb.rd_data = 32'(st_reg.updn);
         tma_pkg::OFF_IRQ_ST: rb.rd_data = 32'(st_reg.irq_st);
         tma_pkg::OFF_IRQ_MSK: rb.rd_data = 32'(st_reg.irq_msk);
         default: rb.rd_data = '0;
      endcase
      for (int i = 0; i < NCH; i++) begin
         if (rb.rd_addr == ch_addr(tma_pkg::OFF_MODE0, i)) begin
            rb.rd_data = {24'h000000, st_reg.mode[i]};
         end
         if (rb.rd_addr == ch_addr(tma_pkg::OFF_COUNT0, i)) begin
            if (reload_now[i]) begin
               rb.rd_data = {16'h0000, tma_pkg::ALL_ONES};
            end else if (over_now[i]) begin
               rb.rd_data = {16'h0000, tma_pkg::CNT_RST};
            end else begin
               rb.rd_data = {16'h0000, st_reg.cnt[i]};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state: registers, counters and requests
   always_comb begin
      logic [NCH-1:0] irq_set;
      logic trig;
      tma_pkg::tma_trig_t ts;
      irq_set = '0;
      trig = 1'b0;
      ts = tma_pkg::TMA_TRG_SW;
      st_next = st_reg;
      st_next.sync1 = timer_input_pin;
      st_next.sync2 = st_reg.sync1;
      st_next.prev = st_reg.sync2;
      st_next.div = div_tick ? 16'h0000 : st_reg.div + 16'h0001;
      st_next.stop_d = '0;
      st_next.oneshot_start_flags_reg[NCH-1:0] = '0; // Software triggers are one-cycle strobes
      // Register writes
      if (rb.wr_en) begin
         case (rb.wr_addr)
            tma_pkg::OFF_START: st_next.start = rb.wr_data[NCH-1:0];
            tma_pkg::OFF_ONESHOT: st_next.oneshot_start_flags_reg = rb.wr_data[7:0];
            tma_pkg::OFF_TRIGSEL: st_next.tsel = rb.wr_data[7:0];
            tma_pkg::OFF_UPDOWN: st_next.updn = rb.wr_data[NCH-1:0];
            tma_pkg::OFF_IRQ_MSK: st_next.irq_msk = rb.wr_data[NCH-1:0];
            default: st_next.start = st_reg.start;
         endcase
      end
      for (int i = 0; i < NCH; i++) begin
         ts = tma_pkg::tma_trig_t'(st_reg.tsel[i*tma_pkg::TSEL_W +: tma_pkg::TSEL_W]);
         case (ts)
            tma_pkg::TMA_TRG_FALL: trig = fall[i];
            tma_pkg::TMA_TRG_RISE: trig = rise[i];
            tma_pkg::TMA_TRG_BOTH: trig = rise[i] || fall[i];
            default: trig = 1'b0;
         endcase
         trig = trig || st_reg.oneshot_start_flags_reg[i];
         // Mode write: entering one-shot from another mode requests
         if (rb.wr_en && rb.wr_addr == ch_addr(tma_pkg::OFF_MODE0, i)) begin
            st_next.mode[i] = rb.wr_data[7:0];
            if (mode_of(rb.wr_data[7:0]) == tma_pkg::TMA_MODE_ONESHOT
                  && mode_of(st_reg.mode[i]) != tma_pkg::TMA_MODE_ONESHOT) begin
               irq_set[i] = 1'b1;
            end
         end
         // Counting, only while started
         if (st_reg.start[i]) begin
            case (mode_of(st_reg.mode[i]))
               tma_pkg::TMA_MODE_TIMER: begin
                  if (reload_now[i]) begin
                     st_next.cnt[i] = st_reg.rld[i];
                     irq_set[i] = 1'b1;
                  end else if (tick[i]) begin
                     st_next.cnt[i] = st_reg.cnt[i] - 16'h0001;
                  end
               end
               tma_pkg::TMA_MODE_EVENT: begin
                  if (reload_now[i] || over_now[i]) begin
                     st_next.cnt[i] = st_reg.rld[i];
                     irq_set[i] = 1'b1;
                  end else if (rise[i]) begin
                     st_next.cnt[i] = st_reg.updn[i] ? st_reg.cnt[i] + 16'h0001
                        : st_reg.cnt[i] - 16'h0001;
                  end
               end
               tma_pkg::TMA_MODE_ONESHOT: begin
                  // Triggers wait for the count source so the pulse is aligned
                  if (trig) st_next.pend1[i] = 1'b1;
                  if (tick[i]) begin
                     if (st_reg.pend1[i] && !st_reg.run[i]) begin
                        st_next.pend1[i] = 1'b0;
                        st_next.run[i] = 1'b1;
                        st_next.out[i] = 1'b1;
                        st_next.cnt[i] = st_reg.rld[i];
                     end else if (st_reg.run[i]) begin
                        if (st_reg.pend2[i]) begin
                           st_next.pend2[i] = 1'b0;
                           st_next.cnt[i] = st_reg.rld[i];
                        end else if (st_reg.cnt[i] == tma_pkg::CNT_RST) begin
                           st_next.run[i] = 1'b0;
                           st_next.out[i] = 1'b0;
                           st_next.cnt[i] = st_reg.rld[i];
                           irq_set[i] = 1'b1;
                        end else begin
                           st_next.cnt[i] = st_reg.cnt[i] - 16'h0001;
                           if (st_reg.pend1[i]) begin
                              st_next.pend1[i] = 1'b0;
                              st_next.pend2[i] = 1'b1;
                           end
                        end
                     end
                  end
               end
               default: st_next.cnt[i] = st_reg.cnt[i];
            endcase
         end
         // Start bit cleared in one-shot: halt, reload, drop output
         if (st_reg.start[i] && !st_next.start[i]
               && mode_of(st_reg.mode[i]) == tma_pkg::TMA_MODE_ONESHOT) begin
            st_next.run[i] = 1'b0;
            st_next.out[i] = 1'b0;
            st_next.pend1[i] = 1'b0;
            st_next.pend2[i] = 1'b0;
            st_next.cnt[i] = st_reg.rld[i];
            st_next.stop_d[i] = 1'b1;
         end
         if (st_reg.stop_d[i]) irq_set[i] = 1'b1;
         if (!st_reg.start[i]) begin
            st_next.run[i] = 1'b0;
            st_next.pend1[i] = 1'b0;
            st_next.pend2[i] = 1'b0;
         end
         // Counter write: reload always, counter too while stopped
         if (rb.wr_en && rb.wr_addr == ch_addr(tma_pkg::OFF_COUNT0, i)) begin
            st_next.rld[i] = rb.wr_data[15:0];
            if (!st_reg.start[i]) st_next.cnt[i] = rb.wr_data[15:0];
         end
      end
      // Write-one-to-clear; a same-cycle event wins over the clear
      if (rb.wr_en && rb.wr_addr == tma_pkg::OFF_IRQ_ST) begin
         st_next.irq_st = st_reg.irq_st & ~rb.wr_data[NCH-1:0];
      end
      st_next.irq_st = st_next.irq_st | irq_set;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign timer_output_pin = st_reg.out;
   assign irq = |(st_reg.irq_st & st_reg.irq_msk);

   ////////////////////////////////////////////////////////////////////////
   // Checks on channel 0
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   logic cnt0_wr;
   logic cnt0_rd;
   tma_pkg::tma_mode_t m0;
   assign cnt0_wr = rb.wr_en && rb.wr_addr == tma_pkg::OFF_COUNT0;
   assign cnt0_rd = rb.rd_en && rb.rd_addr == tma_pkg::OFF_COUNT0;
   assign m0 = mode_of(st_reg.mode[0]);

   sequence os_stop_s;
      st_reg.start[0] && !st_next.start[0] && m0 == tma_pkg::TMA_MODE_ONESHOT;
   endsequence
   sequence os_halt_s;
      !timer_output_pin[0] && !st_reg.run[0] && st_reg.cnt[0] == st_reg.rld[0];
   endsequence

   idle_hold_a: assert property (!st_reg.start[0] && !cnt0_wr
      |=> $stable(st_reg.cnt[0]))
      else $error("stopped channel counter moved");
   live_read_a: assert property (cnt0_rd && st_reg.start[0] && !reload_now[0]
      && !over_now[0] |=> rdata[15:0] == $past(st_reg.cnt[0]))
      else $error("live read returned wrong count");
   reload_read_a: assert property (cnt0_rd && reload_now[0]
      && m0 == tma_pkg::TMA_MODE_TIMER |=> rdata == 32'h0000FFFF)
      else $error("reload read not all ones");
   written_read_a: assert property (cnt0_wr && !st_reg.start[0] && !st_next.start[0]
      |=> st_reg.cnt[0] == $past(rb.wr_data[15:0])
      && st_reg.rld[0] == $past(rb.wr_data[15:0]))
      else $error("stopped write not held");
   event_over_a: assert property (cnt0_rd && over_now[0]
      |=> rdata == 32'h00000000)
      else $error("overflow read not zero");
   os_stop_a: assert property (os_stop_s |=> os_halt_s)
      else $error("one-shot stop did not halt");
   os_stop_irq_a: assert property (os_stop_s |=> ##1 st_reg.irq_st[0])
      else $error("one-shot stop request late");
   out_align_a: assert property ($rose(timer_output_pin[0])
      |-> $past(tick[0]))
      else $error("output rose off count source");
   mode_irq_a: assert property (rb.wr_en && rb.wr_addr == tma_pkg::OFF_MODE0
      && rb.wr_data[1:0] == 2'b10 && m0 != tma_pkg::TMA_MODE_ONESHOT
      |=> st_reg.irq_st[0])
      else $error("one-shot select gave no request");
   retrig_a: assert property (st_reg.start[0] && st_reg.run[0] && st_reg.pend2[0]
      && tick[0] && st_next.start[0] |=> st_reg.cnt[0] == $past(st_reg.rld[0]))
      else $error("retrigger did not reload");
   underflow_a: assert property (reload_now[0] && m0 == tma_pkg::TMA_MODE_TIMER
      && !cnt0_wr |=> st_reg.cnt[0] == $past(st_reg.rld[0]) && st_reg.irq_st[0])
      else $error("underflow did not reload");
endmodule

// ===== sim/tma_trig_src.sv
// Model of the trigger and event source on the timer input pins.
// Assumes fire() is called right after a rising edge of aclk.
`timescale 1ns/100ps
module tma_trig_src #(
   parameter int NCH = 3
) (
   input wire logic aclk,
   output logic [NCH-1:0] pin
);
   ////////////////////////////////////////
   // Pins rest low between pulses
   initial begin
      pin = '0;
   end
   // One pulse, then a low gap never shorter than two cycles
   task automatic fire(input int ch, input int hi, input int lo);
      pin[ch] <= 1'b1;
      repeat (hi) @(posedge aclk);
      pin[ch] <= 1'b0;
      repeat ((lo < 2) ? 2 : lo) @(posedge aclk);
   endtask
endmodule

// ===== sim/timer_a_count_oneshot_tb_top.sv
// Self-checking bench of the three-channel timer over AXI4-Lite.
// Assumes the trigger model and the design files are compiled first.
`timescale 1ns/100ps
module timer_a_count_oneshot_tb_top;
   localparam int NCH = 3;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, r, r1;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [NCH-1:0] timer_input_pin, timer_output_pin;
   int n_mismatch, cmp_count, n, d1, d2, ch;
   integer seed;
   ////////////////////////////////////////
   tma_timer #(.NCH(NCH), .PRESCALE(2)) u_dut (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .timer_input_pin(timer_input_pin),
      .timer_output_pin(timer_output_pin), .irq(irq));
   tma_trig_src #(.NCH(NCH)) u_src (.aclk(aclk), .pin(timer_input_pin));
   // 40 MHz clock
   always #12.5 aclk = ~aclk;
   ////////////////////////////////////////
   // Write: address and data offered together, one edge of rest after
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge aclk); while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      while (bvalid !== 1'b1) @(posedge aclk);
      chk("bresp", 32'(tma_pkg::RESP_OKAY), 32'(bresp));
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   // Read: data belongs to the address handshake cycle
   task automatic axr(input logic [7:0] a, output logic [31:0] d);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      chk("rresp", 32'(tma_pkg::RESP_OKAY), 32'(rresp));
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Bounded wait for a level on channel 0 output
   task automatic wait_out(input logic v, output int k);
      k = 0;
      while (timer_output_pin[0] !== v && k < 400) begin
         @(posedge aclk);
         k++;
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////
   // Watchdog far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      complete_run();
   end
   // Main sequence
   initial begin
      {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      seed = 16170;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axr(tma_pkg::OFF_COUNT0, r);
      chk("count_rst", 32'h0, r);
      chk("out_rst", 32'h0, 32'(timer_output_pin));
      axr(8'hFC, r);
      chk("unmapped", 32'h0, r);
      // Stopped write on a random channel reads back unchanged
      ch = {$random(seed)} % NCH;
      r1 = {16'h0, 16'($random(seed))};
      axw(tma_pkg::OFF_COUNT0 + 8'(4 * ch), r1);
      repeat (5) @(posedge aclk);
      axr(tma_pkg::OFF_COUNT0 + 8'(4 * ch), r);
      chk("stopped_wr", r1, r);
      $display("test reset and stopped write done");
      // Timer mode: live count, underflow request, mask
      axw(tma_pkg::OFF_MODE0, 32'h0);
      axw(tma_pkg::OFF_IRQ_MSK, 32'h1);
      axw(tma_pkg::OFF_COUNT0, 32'h100);
      axw(tma_pkg::OFF_START, 32'h1);
      axr(tma_pkg::OFF_COUNT0, r1);
      axr(tma_pkg::OFF_COUNT0, r);
      chk("live_step", 32'h3, r1 - r);
      n = 0;
      while (irq !== 1'b1 && n < 400) begin
         @(posedge aclk);
         n++;
      end
      chk("irq_up", 32'h1, 32'(irq));
      axw(tma_pkg::OFF_IRQ_MSK, 32'h0);
      chk("irq_masked", 32'h0, 32'(irq));
      axw(tma_pkg::OFF_START, 32'h0);
      axw(tma_pkg::OFF_IRQ_ST, 32'h7);
      axr(tma_pkg::OFF_IRQ_ST, r);
      chk("w1c", 32'h0, r);
      // Zero reload reloads at every tick, so every read meets a reload
      axw(tma_pkg::OFF_COUNT0, 32'h0);
      axw(tma_pkg::OFF_START, 32'h1);
      axr(tma_pkg::OFF_COUNT0, r);
      chk("reload_read", 32'hFFFF, r);
      axw(tma_pkg::OFF_START, 32'h0);
      $display("test timer mode done");
      // Event mode down then up, random number of pin edges
      axw(tma_pkg::OFF_MODE0, 32'h1);
      for (int d = 0; d < 2; d++) begin
         n = {$random(seed)} % 4 + 1;
         axw(tma_pkg::OFF_UPDOWN, 32'(d));
         axw(tma_pkg::OFF_COUNT0, 32'h5);
         axw(tma_pkg::OFF_START, 32'h1);
         repeat (n) u_src.fire(0, 3, 3);
         repeat (5) @(posedge aclk);
         axr(tma_pkg::OFF_COUNT0, r);
         chk("event_count", (d == 1) ? 32'(5 + n) : 32'(5 - n), r);
         axw(tma_pkg::OFF_START, 32'h0);
         // Wrap value loaded, read lands in the cycle the synced edge is seen
         axw(tma_pkg::OFF_COUNT0, (d == 1) ? 32'hFFFF : 32'h0);
         axw(tma_pkg::OFF_START, 32'h1);
         fork
            u_src.fire(0, 3, 3);
            begin
               repeat (2) @(posedge aclk);
               axr(tma_pkg::OFF_COUNT0, r);
            end
         join
         chk("event_wrap", (d == 1) ? 32'h0 : 32'hFFFF, r);
         axw(tma_pkg::OFF_START, 32'h0);
      end
      $display("test event mode done");
      // One-shot: mode change request, pin trigger, retrigger, stop
      // Old requests cleared so only the mode change can raise one
      axw(tma_pkg::OFF_IRQ_ST, 32'h7);
      axw(tma_pkg::OFF_MODE0, 32'h2);
      axr(tma_pkg::OFF_IRQ_ST, r);
      chk("mode_req", 32'h1, r & 32'h1);
      axw(tma_pkg::OFF_IRQ_ST, 32'h1);
      axw(tma_pkg::OFF_TRIGSEL, 32'h2);
      axw(tma_pkg::OFF_COUNT0, 32'hA);
      axw(tma_pkg::OFF_START, 32'h1);
      fork
         u_src.fire(0, 2, 2);
         wait_out(1'b1, n);
      join
      chk("trig_lag", 32'h1, 32'(n <= 6));
      wait_out(1'b0, d1);
      chk("pulse_len", 32'h1, 32'(d1 >= 8 && d1 < 400));
      fork
         begin
            u_src.fire(0, 2, 6);
            u_src.fire(0, 2, 2);
         end
         begin
            wait_out(1'b1, n);
            wait_out(1'b0, d2);
         end
      join
      chk("retrig_longer", 32'h1, 32'(d2 > d1 && d2 < 400));
      axw(tma_pkg::OFF_IRQ_ST, 32'h1);
      axw(tma_pkg::OFF_ONESHOT, 32'h1);
      wait_out(1'b1, n);
      axw(tma_pkg::OFF_START, 32'h0);
      chk("stop_out", 32'h0, 32'(timer_output_pin[0]));
      axr(tma_pkg::OFF_COUNT0, r);
      chk("stop_reload", 32'hA, r);
      axr(tma_pkg::OFF_IRQ_ST, r);
      chk("stop_req", 32'h1, r & 32'h1);
      $display("test one-shot mode done");
      complete_run();
   end
endmodule
